// >>> src/flash_reset_and_write_guard.sv
// reset and write protection control of a serial flash device.
// assumes sclk, cs_n and io_in are asynchronous pins, sys_rst is the
// internal power-on reset, and the serial clock is at least 8x slower.
`include "flash_guard_cfg.svh"

module flash_reset_and_write_guard
  import flash_guard_pkg::*;
#(
  parameter int OP_CYCLES = `OP_CYCLES_DEFAULT,
  parameter int PU_CYCLES = `POWERUP_WRITE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic busy_flag,
  output logic write_enable_latch,
  output logic quad_lines_enable,
  output logic four_line_instruction_mode,
  output logic deep_power_down
);

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // opcode to instruction class
  function automatic cmd_class_t class_of(input logic [7:0] opc);
    unique case (opc)
      `OPC_WREN: class_of = CL_WREN;
      `OPC_WRDI: class_of = CL_WRDI;
      `OPC_RDSR1, `OPC_RDSR2, `OPC_RDSR3: class_of = CL_RDSR;
      `OPC_WRSR1, `OPC_WRSR2, `OPC_WRSR3: class_of = CL_WRSR;
      `OPC_PP, `OPC_QPP, `OPC_SECPG: class_of = CL_PROG;
      `OPC_SE, `OPC_BE32, `OPC_BE64, `OPC_CE1, `OPC_CE2,
      `OPC_SECER: class_of = CL_ERASE;
      `OPC_SUSP: class_of = CL_SUSP;
      `OPC_RESUME: class_of = CL_RESUME;
      `OPC_PD: class_of = CL_PD;
      `OPC_RELPD: class_of = CL_RELPD;
      `OPC_QPI_ON: class_of = CL_QPI_ON;
      `OPC_QPI_OFF: class_of = CL_QPI_OFF;
      `OPC_RST_ARM: class_of = CL_ARM;
      `OPC_RST: class_of = CL_RST;
      default: class_of = CL_NONE;
    endcase
  endfunction

  // whether the device state lets an instruction class in
  function automatic logic admits(input cmd_class_t cls,
                                  input op_state_t op,
                                  input logic pd,
                                  input logic pu_done);
    logic wr;
    wr = (cls == CL_WREN) || (cls == CL_WRSR) ||
         (cls == CL_PROG) || (cls == CL_ERASE);
    if (op == OP_SRST) begin
      admits = 1'b0;
    end else if (pd) begin
      admits = (cls == CL_RELPD);
    end else if (op == OP_RUN) begin
      admits = (cls == CL_RDSR) || (cls == CL_SUSP);
    end else if (wr && !pu_done) begin
      admits = 1'b0;
    end else begin
      admits = (cls != CL_NONE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect

  logic cs_m_q, cs_s_q, cs_d_q;
  logic sclk_m_q, sclk_s_q, sclk_d_q;
  logic [3:0] io_m_q, io_s_q;

  // two flops per pin, one more for edges
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_d_q <= 1'b0;
      io_m_q <= 4'hf;
      io_s_q <= 4'hf;
    end else begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      sclk_m_q <= sclk;
      sclk_s_q <= sclk_m_q;
      sclk_d_q <= sclk_s_q;
      io_m_q <= io_in;
      io_s_q <= io_m_q;
    end
  end

  logic sclk_rise, sclk_fall, cs_rise;
  assign sclk_rise = sclk_s_q & ~sclk_d_q;
  assign sclk_fall = ~sclk_s_q & sclk_d_q;
  assign cs_rise = cs_s_q & ~cs_d_q;

  ////////////////////////////////////////////////////////////////////////
  // status fields

  logic [2:0] protect_extent_q;
  logic protect_from_low_end_q, protect_granule_q, protect_invert_q;
  logic status_guard_lo_q, status_guard_hi_q, quad_lines_enable_q;
  logic [2:0] lock_bits_q;
  logic suspended_q, hold_or_reset_q;
  logic [1:0] drive_q;
  logic busy_q, wel_q, qpi_q, pd_q, armed_q, pu_done_q;
  op_state_t op_q;

  ////////////////////////////////////////////////////////////////////////
  // shared pin role and hardware reset

  logic pin_reset_low, hold_low, hw_fire;
  logic [7:0] rst_cnt_q;

  // pin role from config and quad bit
  assign pin_reset_low = ~quad_lines_enable_q & hold_or_reset_q & ~io_s_q[3];
  assign hold_low = ~quad_lines_enable_q & ~hold_or_reset_q & ~io_s_q[3] &
                    ~cs_s_q;

  // low time qualifier, fires once per pulse
  always_ff @(posedge clock) begin
    if (sys_rst || !pin_reset_low) begin
      rst_cnt_q <= 8'h00;
    end else if (rst_cnt_q != 8'(`RESET_PULSE_CYC)) begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end
  assign hw_fire = pin_reset_low &&
                   (rst_cnt_q == 8'(`RESET_PULSE_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // instruction shifter

  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic have_cmd_q, byte_done;
  cmd_class_t cls_q;
  logic [7:0] opc_q, data0_q, data1_q;
  logic [1:0] nbytes_q;
  logic frame_clr;

  // pin low overrides the serial bus
  assign frame_clr = cs_s_q | pin_reset_low;
  assign shift_d = qpi_q ? {shift_q[3:0], io_s_q} :
                           {shift_q[6:0], io_s_q[0]};
  assign bit_cnt_d = bit_cnt_q + (qpi_q ? 4'h4 : 4'h1);
  assign byte_done = sclk_rise & ~hold_low & (bit_cnt_d == 4'h8);

  // bit and byte collection
  always_ff @(posedge clock) begin
    if (sys_rst || frame_clr) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      have_cmd_q <= 1'b0;
      cls_q <= CL_NONE;
      opc_q <= 8'h00;
      data0_q <= 8'h00;
      data1_q <= 8'h00;
      nbytes_q <= 2'h0;
    end else if (sclk_rise && !hold_low) begin
      shift_q <= shift_d;
      bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_d;
      if (byte_done && !have_cmd_q) begin
        have_cmd_q <= 1'b1;
        opc_q <= shift_d;
        cls_q <= class_of(shift_d);
      end else if (byte_done) begin
        if (nbytes_q == 2'h0) begin
          data0_q <= shift_d;
        end else if (nbytes_q == 2'h1) begin
          data1_q <= shift_d;
        end
        if (nbytes_q != 2'h3) begin
          nbytes_q <= nbytes_q + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execution decisions at end of frame

  logic frame_end, exec, sr_open, start_op, srst_go, dev_reset, op_done;

  // whole bytes only; the reset pin blocks the frame entirely
  assign frame_end = cs_rise & have_cmd_q & (bit_cnt_q == 4'h0) &
                     ~pin_reset_low;
  // sys_rst holds every flop, nothing executes
  assign exec = frame_end & admits(cls_q, op_q, pd_q, pu_done_q);

  always_comb begin
    unique case ({status_guard_hi_q, status_guard_lo_q})
      2'b00: sr_open = 1'b1;
      2'b01: sr_open = quad_lines_enable_q | io_s_q[2];
      default: sr_open = 1'b0;
    endcase
  end

  // program, erase and status write need the latch
  assign start_op = exec & (op_q == OP_IDLE) & wel_q &
                    ((cls_q == CL_PROG) || (cls_q == CL_ERASE) ||
                     ((cls_q == CL_WRSR) && sr_open &&
                      (nbytes_q != 2'h0)));
  // armed pair completes the soft reset
  assign srst_go = exec & (cls_q == CL_RST) & armed_q;
  assign dev_reset = hw_fire | srst_go;

  // arm survives only to the very next instruction
  always_ff @(posedge clock) begin
    if (sys_rst || dev_reset) begin
      armed_q <= 1'b0;
    end else if (frame_end) begin
      armed_q <= exec && (cls_q == CL_ARM);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation sequencer

  logic [15:0] op_cnt_q;
  assign op_done = (op_q == OP_RUN) && (op_cnt_q == 16'h0000);

  // busy, suspend and soft reset timing
  always_ff @(posedge clock) begin
    if (sys_rst || hw_fire) begin
      op_q <= OP_IDLE;
      op_cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      suspended_q <= 1'b0;
    end else if (srst_go) begin
      op_q <= OP_SRST;
      op_cnt_q <= 16'(`SOFT_RESET_CYC - 1);
      busy_q <= 1'b0;
      suspended_q <= 1'b0;
    end else begin
      unique case (op_q)
        OP_IDLE: begin
          if (start_op) begin
            op_q <= OP_RUN;
            op_cnt_q <= 16'(OP_CYCLES - 1);
            busy_q <= 1'b1;
          end
        end
        OP_RUN: begin
          if (exec && cls_q == CL_SUSP) begin
            op_q <= OP_SUSP;
            busy_q <= 1'b0;
            suspended_q <= 1'b1;
          end else if (op_done) begin
            op_q <= OP_IDLE;
            busy_q <= 1'b0;
          end else begin
            op_cnt_q <= op_cnt_q - 16'h0001;
          end
        end
        OP_SUSP: begin
          if (exec && cls_q == CL_RESUME) begin
            op_q <= OP_RUN;
            busy_q <= 1'b1;
            suspended_q <= 1'b0;
          end
        end
        OP_SRST: begin
          if (op_cnt_q == 16'h0000) begin
            op_q <= OP_IDLE;
          end else begin
            op_cnt_q <= op_cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write enable latch, modes and power-up delay

  logic [19:0] pu_cnt_q;

  always_ff @(posedge clock) begin
    if (sys_rst || dev_reset) begin
      wel_q <= 1'b0;
    end else if (op_done) begin
      wel_q <= 1'b0;
    end else if (exec && cls_q == CL_WREN) begin
      wel_q <= 1'b1;
    end else if (exec && cls_q == CL_WRDI) begin
      wel_q <= 1'b0;
    end
  end

  // four-line mode and deep power-down
  always_ff @(posedge clock) begin
    if (sys_rst || dev_reset) begin
      qpi_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (exec) begin
      if (cls_q == CL_QPI_ON && quad_lines_enable_q) begin
        qpi_q <= 1'b1;
      end else if (cls_q == CL_QPI_OFF) begin
        qpi_q <= 1'b0;
      end
      if (cls_q == CL_PD && op_q == OP_IDLE) begin
        pd_q <= 1'b1;
      end else if (cls_q == CL_RELPD) begin
        pd_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pu_cnt_q <= 20'h00000;
      pu_done_q <= 1'b0;
    end else if (!pu_done_q) begin
      pu_cnt_q <= pu_cnt_q + 20'h00001;
      pu_done_q <= (pu_cnt_q == 20'(PU_CYCLES - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register writes

  logic wr_sr1, wr_sr2, wr_sr3;
  logic [7:0] sr2_src;
  // guard reset value split into its two bits
  localparam logic [1:0] SRP_RESET = `RST_SRP;
  assign wr_sr1 = start_op && opc_q == `OPC_WRSR1;
  assign wr_sr2 = start_op && ((opc_q == `OPC_WRSR1 && nbytes_q != 2'h1) ||
                               opc_q == `OPC_WRSR2);
  assign wr_sr3 = start_op && opc_q == `OPC_WRSR3;
  assign sr2_src = (opc_q == `OPC_WRSR1) ? data1_q : data0_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      protect_extent_q <= `RST_BP;
      protect_from_low_end_q <= `RST_TB;
      protect_granule_q <= `RST_SEC;
      status_guard_lo_q <= SRP_RESET[0];
      status_guard_hi_q <= SRP_RESET[1];
      protect_invert_q <= `RST_CMP;
      quad_lines_enable_q <= `RST_QE;
      lock_bits_q <= `RST_LB;
      drive_q <= `RST_DRV;
      hold_or_reset_q <= `RST_HOLD_RST;
    end else begin
      if (wr_sr1) begin
        protect_extent_q <= data0_q[`SR1_BP_LO +: 3];
        protect_from_low_end_q <= data0_q[`SR1_TB];
        protect_granule_q <= data0_q[`SR1_SEC];
        status_guard_lo_q <= data0_q[`SR1_STATUS_GUARD_LO];
      end
      if (wr_sr2) begin
        status_guard_hi_q <= sr2_src[`SR2_STATUS_GUARD_HI];
        protect_invert_q <= sr2_src[`SR2_CMP];
        // quad bit cannot be cleared from four-line mode
        quad_lines_enable_q <= sr2_src[`SR2_QE] | qpi_q;
        // one-time lock bits only ever set
        lock_bits_q <= lock_bits_q | sr2_src[`SR2_LB_LO +: 3];
      end
      if (wr_sr3) begin
        drive_q <= data0_q[`SR3_DRV_LO +: 2];
        hold_or_reset_q <= data0_q[`SR3_HOLD_RST];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status read out

  logic [7:0] sr1_v, sr2_v, sr3_v, rd_v, tx_q, tx_cur;
  logic [1:0] rd_sel_q;
  logic [2:0] tx_cnt_q;
  logic tx_on_q;

  always_comb begin
    sr1_v = 8'h00;
    sr1_v[`SR1_BUSY] = busy_q;
    sr1_v[`SR1_WEL] = wel_q;
    sr1_v[`SR1_BP_LO +: 3] = protect_extent_q;
    sr1_v[`SR1_TB] = protect_from_low_end_q;
    sr1_v[`SR1_SEC] = protect_granule_q;
    sr1_v[`SR1_STATUS_GUARD_LO] = status_guard_lo_q;
    sr2_v = 8'h00;
    sr2_v[`SR2_STATUS_GUARD_HI] = status_guard_hi_q;
    sr2_v[`SR2_QE] = quad_lines_enable_q;
    sr2_v[`SR2_LB_LO +: 3] = lock_bits_q;
    sr2_v[`SR2_CMP] = protect_invert_q;
    sr2_v[`SR2_SUS] = suspended_q;
    sr3_v = 8'h00;
    sr3_v[`SR3_DRV_LO +: 2] = drive_q;
    sr3_v[`SR3_HOLD_RST] = hold_or_reset_q;
    unique case (rd_sel_q)
      2'h1: rd_v = sr2_v;
      2'h2: rd_v = sr3_v;
      default: rd_v = sr1_v;
    endcase
  end

  // reread the live value at each byte boundary
  assign tx_cur = (tx_cnt_q == 3'h0) ? rd_v : tx_q;

  // read start once the opcode byte is in
  always_ff @(posedge clock) begin
    if (sys_rst || frame_clr || dev_reset) begin
      tx_on_q <= 1'b0;
      rd_sel_q <= 2'h0;
    end else if (byte_done && !have_cmd_q &&
                 class_of(shift_d) == CL_RDSR &&
                 admits(CL_RDSR, op_q, pd_q, pu_done_q)) begin
      tx_on_q <= 1'b1;
      rd_sel_q <= (shift_d == `OPC_RDSR2) ? 2'h1 :
                  (shift_d == `OPC_RDSR3) ? 2'h2 : 2'h0;
    end
  end

  // data out on falling serial clock edges
  always_ff @(posedge clock) begin
    if (sys_rst || frame_clr || hold_low || !tx_on_q) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      tx_q <= 8'h00;
      tx_cnt_q <= 3'h0;
    end else if (sclk_fall) begin
      if (qpi_q) begin
        io_out <= tx_cur[7:4];
        io_oe <= 4'hf;
        tx_q <= {tx_cur[3:0], 4'h0};
        tx_cnt_q <= tx_cnt_q + 3'h4;
      end else begin
        io_out <= {2'b00, tx_cur[7], 1'b0};
        io_oe <= 4'h2;
        tx_q <= {tx_cur[6:0], 1'b0};
        tx_cnt_q <= tx_cnt_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state outputs

  assign busy_flag = busy_q;
  assign write_enable_latch = wel_q;
  assign quad_lines_enable = quad_lines_enable_q;
  assign four_line_instruction_mode = qpi_q;
  assign deep_power_down = pd_q;

endmodule // flash_reset_and_write_guard

// >>> src/flash_guard_cfg.svh
// constants of the flash reset and write guard: opcodes, status bit
// positions, reset values and timing counts.
// assumes a 10 MHz core clock and a serial clock much slower than it.
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH

// opcodes
`define OPC_WREN 8'h06
`define OPC_WRDI 8'h04
`define OPC_RDSR1 8'h05
`define OPC_RDSR2 8'h35
`define OPC_RDSR3 8'h15
`define OPC_WRSR1 8'h01
`define OPC_WRSR2 8'h31
`define OPC_WRSR3 8'h11
`define OPC_PP 8'h02
`define OPC_QPP 8'h32
`define OPC_SE 8'h20
`define OPC_BE32 8'h52
`define OPC_BE64 8'hd8
`define OPC_CE1 8'hc7
`define OPC_CE2 8'h60
`define OPC_SECER 8'h44
`define OPC_SECPG 8'h42
`define OPC_SUSP 8'h75
`define OPC_RESUME 8'h7a
`define OPC_PD 8'hb9
`define OPC_RELPD 8'hab
`define OPC_QPI_ON 8'h38
`define OPC_QPI_OFF 8'hff
`define OPC_RST_ARM 8'h66
`define OPC_RST 8'h99

// status register bit positions
`define SR1_BUSY 0
`define SR1_WEL 1
`define SR1_BP_LO 2
`define SR1_TB 5
`define SR1_SEC 6
`define SR1_STATUS_GUARD_LO 7
`define SR2_STATUS_GUARD_HI 0
`define SR2_QE 1
`define SR2_LB_LO 3
`define SR2_CMP 6
`define SR2_SUS 7
`define SR3_DRV_LO 5
`define SR3_HOLD_RST 7

// reset values of the writable fields
`define RST_BP 3'h0
`define RST_TB 1'h0
`define RST_SEC 1'h0
`define RST_CMP 1'h0
`define RST_SRP 2'h0
`define RST_QE 1'h0
`define RST_LB 3'h0
`define RST_DRV 2'h1
`define RST_HOLD_RST 1'h0

// timing
`define CLOCK_PERIOD_NS 100
`define SOFT_RESET_TIME_US 28
`define RESET_PULSE_MIN_US 1
`define POWERUP_WRITE_DELAY_US 1000
`define OP_CYCLES_DEFAULT 64
`define SOFT_RESET_CYC \
  ((`SOFT_RESET_TIME_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define RESET_PULSE_CYC \
  ((`RESET_PULSE_MIN_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define POWERUP_WRITE_CYC \
  ((`POWERUP_WRITE_DELAY_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// >>> src/flash_guard_pkg.sv
// types of the flash reset and write guard.
// assumes nothing beyond the constants header.
package flash_guard_pkg;

  // internal operation state
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_RUN,
    OP_SUSP,
    OP_SRST
  } op_state_t;

  // instruction classes
  typedef enum logic [3:0] {
    CL_NONE,
    CL_WREN,
    CL_WRDI,
    CL_RDSR,
    CL_WRSR,
    CL_PROG,
    CL_ERASE,
    CL_SUSP,
    CL_RESUME,
    CL_PD,
    CL_RELPD,
    CL_QPI_ON,
    CL_QPI_OFF,
    CL_ARM,
    CL_RST
  } cmd_class_t;

endpackage

// >>> sim/flash_guard_props.sv
// assertions on the ports of the flash reset and write guard.
// assumes one core clock and an active-high synchronous reset.
module flash_guard_props
  import flash_guard_pkg::*;
#(
  parameter int OP_CYCLES = 64,
  parameter int PU_CYCLES = 10000
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  input wire logic busy_flag,
  input wire logic write_enable_latch,
  input wire logic deep_power_down
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  int pu_cnt_q;
  int busy_cnt_q;

  // cycles since reset release, saturating
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pu_cnt_q <= 0;
    end else if (pu_cnt_q < PU_CYCLES) begin
      pu_cnt_q <= pu_cnt_q + 1;
    end
  end

  // length of the current busy stretch
  always_ff @(posedge clock) begin
    if (sys_rst || !busy_flag) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_deselected;
    cs_n [*4];
  endsequence
  sequence s_busy_start;
    $rose(busy_flag);
  endsequence

  a_wel_at_reset: assert property (
    $fell(sys_rst) |-> !write_enable_latch) else $error("latch after reset");
  a_idle_at_reset: assert property (
    $fell(sys_rst) |-> !busy_flag && !deep_power_down)
    else $error("busy or sleep after reset");
  a_wel_after_delay: assert property (
    $rose(write_enable_latch) |-> pu_cnt_q >= PU_CYCLES)
    else $error("latch set in power-up delay");
  a_wel_set_idle: assert property (
    $rose(write_enable_latch) |-> cs_n && !busy_flag)
    else $error("latch set while busy or selected");
  a_busy_needs_wel: assert property (
    s_busy_start |-> write_enable_latch) else $error("busy without latch");
  a_busy_holds: assert property (
    s_busy_start |-> busy_flag [*8]) else $error("busy too short");
  a_busy_end_wel: assert property (
    $fell(busy_flag) |-> !write_enable_latch)
    else $error("latch kept after operation");
  a_busy_bounded: assert property (
    busy_cnt_q <= OP_CYCLES + 1) else $error("busy too long");
  a_sleep_no_wel: assert property (
    deep_power_down && $past(deep_power_down) |->
    !$rose(write_enable_latch)) else $error("latch set in power-down");
  a_oe_released: assert property (
    s_deselected |-> io_oe == 4'h0) else $error("driving while deselected");
endmodule // flash_guard_props

bind flash_reset_and_write_guard flash_guard_props #(
  .OP_CYCLES(OP_CYCLES),
  .PU_CYCLES(PU_CYCLES)
) props_inst (
  .clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .io_oe(io_oe),
  .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
  .deep_power_down(deep_power_down)
);

// >>> sim/host.sv
// host controller model driving the serial pins of the flash guard.
// assumes callers start each frame just after a core clock edge.
module host (
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wp_n = 1'b1;
  logic rst_n = 1'b1;
  logic quad = 1'b0;
  logic drv4 = 1'b0;
  logic [3:0] dq = 4'h5;
  logic [7:0] rd_byte = 8'h00;
  event rd_ev;

  // protect and reset lines unless all four carry data
  assign io_in = drv4 ? dq : {rst_n, wp_n, dq[1:0]};

  // clock rests low and chip deselected between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end

  // one byte msb first, 800 ns per serial clock
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      if (quad) dq = b[7 - 4 * i -: 4];
      else dq[0] = b[7 - i];
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
  endtask

  // one instruction with an optional data byte
  task automatic frame(input logic [7:0] op, input int n, input logic [7:0] d);
    drv4 = quad;
    #400 cs_n = 1'b0;
    put_byte(op);
    if (n > 0) put_byte(d);
    #400 cs_n = 1'b1;
    drv4 = 1'b0;
    dq = ~dq;
    #800;
  endtask

  // status read: opcode, then one byte sampled on rising clocks
  task automatic read_reg(input logic [7:0] op);
    #400 cs_n = 1'b0;
    put_byte(op);
    for (int i = 0; i < 8; i++) begin
      #400 sclk = 1'b1;
      // an undriven output line reads as the inverse of its last level
      rd_byte[7 - i] = io_oe[1] ? io_out[1] : ~io_out[1];
      #400 sclk = 1'b0;
    end
    #400 cs_n = 1'b1;
    dq = ~dq;
    -> rd_ev;
    #800;
  endtask
endmodule // host

// >>> sim/tb_flash_reset_and_write_guard.sv
// self-checking bench of the flash reset and write guard.
// assumes the host model drives the pins; core clock 10 MHz.
`include "flash_guard_cfg.svh"

module tb_flash_reset_and_write_guard;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPC = 400;
  localparam int PUC = 200;
  logic clock;
  logic sys_rst;
  logic cs_n;
  logic sclk;
  logic [3:0] io_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic busy_flag;
  logic write_enable_latch;
  logic quad_lines_enable;
  logic four_line_instruction_mode;
  logic deep_power_down;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] lfsr_q = 32'h5600ac85;
  logic [7:0] rnd;
  logic [7:0] exp_q[$];
  logic [7:0] wr_ops[8] = '{`OPC_PP, `OPC_SE, `OPC_BE32, `OPC_BE64,
    `OPC_CE1, `OPC_CE2, `OPC_SECER, `OPC_SECPG};

  flash_reset_and_write_guard #(.OP_CYCLES(OPC), .PU_CYCLES(PUC))
    flash_reset_and_write_guard_inst (
    .clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch),
    .quad_lines_enable(quad_lines_enable),
    .four_line_instruction_mode(four_line_instruction_mode),
    .deep_power_down(deep_power_down));
  host host_inst (.cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic flag(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one frame, then let its effects land
  task automatic cmd(input logic [7:0] op, input int n = 0,
                     input logic [7:0] d = 8'h00);
    @(posedge clock);
    #13;
    host_inst.frame(op, n, d);
    repeat (6) @(posedge clock);
    #13;
  endtask

  // status read, noting the expected byte first
  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    #13;
    host_inst.read_reg(op);
  endtask

  // bounded wait for busy to fall
  task automatic idle_wait;
    for (int i = 0; i < 2 * OPC && busy_flag !== 1'b0; i++) @(posedge clock);
    #13;
  endtask

  // core clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  // compare each finished read with the oldest note
  initial forever begin
    @(host_inst.rd_ev);
    if (exp_q.size() == 0) chk("read note", 8'h00, 8'hff);
    else chk("status read", exp_q.pop_front(), host_inst.rd_byte);
  end

  // stimulus
  initial begin
    sys_rst = 1'b1;
    repeat (4) @(posedge clock);
    #13 sys_rst = 1'b0;
    flag("latch", 1'b0, write_enable_latch);
    cmd(`OPC_WREN);
    flag("latch", 1'b0, write_enable_latch);
    repeat (PUC) @(posedge clock);
    cmd(`OPC_WREN);
    flag("latch", 1'b1, write_enable_latch);
    rd(`OPC_RDSR1, 8'h02);
    rd(`OPC_RDSR2, 8'h00);
    rd(`OPC_RDSR3, 8'h20);
    cmd(`OPC_WRDI);
    flag("latch", 1'b0, write_enable_latch);
    cmd(`OPC_PP);
    flag("busy", 1'b0, busy_flag);
    foreach (wr_ops[i]) begin
      cmd(`OPC_WREN);
      cmd(wr_ops[i]);
      flag("busy", 1'b1, busy_flag);
      rd(`OPC_RDSR1, 8'h03);
      cmd(`OPC_PD);
      flag("sleep", 1'b0, deep_power_down);
      idle_wait();
      flag("busy", 1'b0, busy_flag);
      flag("latch", 1'b0, write_enable_latch);
    end
    // status writes under the guard
    cmd(`OPC_WREN);
    cmd(`OPC_WRSR1, 1, 8'h80);
    idle_wait();
    cmd(`OPC_WREN);
    host_inst.wp_n = 1'b0;
    cmd(`OPC_WRSR1, 1, 8'h04);
    rd(`OPC_RDSR1, 8'h82);
    host_inst.wp_n = 1'b1;
    lfsr_q = lfsr_next(lfsr_q);
    rnd = {1'b0, lfsr_q[4:0], 2'b00};
    cmd(`OPC_WRSR1, 1, rnd);
    idle_wait();
    rd(`OPC_RDSR1, rnd);
    // power-down and soft reset
    cmd(`OPC_PD);
    flag("sleep", 1'b1, deep_power_down);
    cmd(`OPC_WREN);
    flag("latch", 1'b0, write_enable_latch);
    cmd(`OPC_RELPD);
    flag("sleep", 1'b0, deep_power_down);
    cmd(`OPC_RST_ARM);
    cmd(`OPC_WREN);
    cmd(`OPC_RST);
    flag("latch", 1'b1, write_enable_latch);
    cmd(`OPC_RST_ARM);
    cmd(`OPC_RST);
    flag("latch", 1'b0, write_enable_latch);
    cmd(`OPC_WREN);
    flag("latch", 1'b0, write_enable_latch);
    repeat (300) @(posedge clock);
    #13;
    // reset role, then four-line mode
    cmd(`OPC_WREN);
    cmd(`OPC_WRSR3, 1, 8'ha0);
    idle_wait();
    cmd(`OPC_WREN);
    cmd(`OPC_WRSR2, 1, 8'h02);
    idle_wait();
    flag("quad", 1'b1, quad_lines_enable);
    cmd(`OPC_QPI_ON);
    flag("qpi", 1'b1, four_line_instruction_mode);
    host_inst.quad = 1'b1;
    cmd(`OPC_WREN);
    host_inst.rst_n = 1'b0;
    repeat (30) @(posedge clock);
    #13 host_inst.rst_n = 1'b1;
    flag("latch", 1'b1, write_enable_latch);
    cmd(`OPC_RST_ARM);
    cmd(`OPC_RST);
    host_inst.quad = 1'b0;
    flag("qpi", 1'b0, four_line_instruction_mode);
    repeat (300) @(posedge clock);
    #13;
    // hardware reset aborts an erase
    cmd(`OPC_WREN);
    cmd(`OPC_WRSR2, 1, 8'h00);
    idle_wait();
    flag("quad", 1'b0, quad_lines_enable);
    cmd(`OPC_WREN);
    cmd(`OPC_CE1);
    flag("busy", 1'b1, busy_flag);
    // pin held low well beyond 1us
    host_inst.rst_n = 1'b0;
    repeat (15) @(posedge clock);
    #13;
    flag("busy", 1'b0, busy_flag);
    flag("latch", 1'b0, write_enable_latch);
    cmd(`OPC_WREN);
    flag("latch", 1'b0, write_enable_latch);
    host_inst.rst_n = 1'b1;
    cmd(`OPC_WREN);
    flag("latch", 1'b1, write_enable_latch);
    give_verdict();
  end
endmodule // tb_flash_reset_and_write_guard
